//--- verilog/ldfb_defs.svh
// Purpose: constants of the detail signaling field builder
// Assumes: included by the package and by every design file
// Notes:   field code is {group, step}; steps give the emission order
`ifndef LDFB_DEFS_SVH
`define LDFB_DEFS_SVH

// field groups
`define LDFB_GRP_FRAME 3'h0
`define LDFB_GRP_RF    3'h1
`define LDFB_GRP_SUB   3'h2
`define LDFB_GRP_PLP   3'h3

// frame header steps
`define LDFB_F_VER   5'h00
`define LDFB_F_NRF   5'h01
`define LDFB_F_LAST  5'h01
// bonded channel steps
`define LDFB_R_IDENT 5'h00
`define LDFB_R_FREQ  5'h01
// subframe steps
`define LDFB_S_MIMO  5'h00
`define LDFB_S_MISO  5'h01
`define LDFB_S_FFT   5'h02
`define LDFB_S_RED   5'h03
`define LDFB_S_GI    5'h04
`define LDFB_S_NSYM  5'h05
`define LDFB_S_SPP   5'h06
`define LDFB_S_SPB   5'h07
`define LDFB_S_SBSF  5'h08
`define LDFB_S_SBSL  5'h09
`define LDFB_S_MUX   5'h0A
`define LDFB_S_FI    5'h0B
`define LDFB_S_NPLP  5'h0C
`define LDFB_S_LAST  5'h0C
// pipe steps
`define LDFB_P_ID    5'h00
`define LDFB_P_SLT   5'h01
`define LDFB_P_SIZE  5'h02
`define LDFB_P_SCR   5'h03
`define LDFB_P_FEC   5'h04
`define LDFB_P_MOD   5'h05
`define LDFB_P_COD   5'h06
`define LDFB_P_TI    5'h07
`define LDFB_P_NBND  5'h08
`define LDFB_P_BID   5'h09
`define LDFB_P_BFMT  5'h0A
`define LDFB_P_SC    5'h0B
`define LDFB_P_IQ    5'h0C
`define LDFB_P_PH    5'h0D
`define LDFB_P_START 5'h0E
`define LDFB_P_TYPE  5'h0F
`define LDFB_P_NSS   5'h10
`define LDFB_P_SSI   5'h11
`define LDFB_P_EXT   5'h12
`define LDFB_P_DEPTH 5'h13
`define LDFB_P_ROW   5'h14
`define LDFB_P_HINT  5'h15
`define LDFB_P_HTIB  5'h16
`define LDFB_P_HFMX  5'h17
`define LDFB_P_HFEC  5'h18
`define LDFB_P_HCI   5'h19
`define LDFB_P_LAST  5'h19

// values
`define LDFB_FREQ_STEP_KHZ 20'h0000A
`define LDFB_PLP_ID_MAX    8'h3F
`define LDFB_TI_MODE_CTI   2'h1
`define LDFB_RST_STEP      5'h00
`define LDFB_RST_IDX       7'h00

`endif

//--- verilog/ldfb_pkg.sv
// Purpose: types of the detail signaling field builder
// Assumes: ldfb_defs.svh holds all numbers
// Notes:   input counts are natural counts; the block does the minus one, except for bond_total and hti_ti_blocks
`include "ldfb_defs.svh"

package ldfb_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FRAME = 3'b001,
    ST_RF    = 3'b010,
    ST_SUB   = 3'b011,
    ST_PLP   = 3'b100
  } ldfb_state_e;

  typedef struct packed {
    logic [2:0]       version;
    logic [2:0]       rf_total;
    logic [1:0][2:0]  rf_ident;
    logic [1:0][19:0] rf_freq_khz;
  } ldfb_frame_s;

  typedef struct packed {
    logic        mimo;
    logic        miso;
    logic [1:0]  fft;
    logic [2:0]  carrier_red;
    logic [3:0]  guard;
    logic [11:0] sym_total;
    logic [4:0]  pilot;
    logic [2:0]  pilot_amp;
    logic        sbs_first;
    logic        sbs_last;
    logic        concat;
    logic        fi_en;
    logic [6:0]  plp_total;
  } ldfb_sub_s;

  typedef struct packed {
    logic [7:0]  id;
    logic        slt;
    logic [23:0] size;
    logic [1:0]  scrambler;
    logic [3:0]  fec;
    logic [3:0]  modulation;
    logic [3:0]  code_rate;
    logic [1:0]  ti_mode;
    logic [1:0]  bond_total;
    logic [2:0]  bond_ident;
    logic [1:0]  bond_fmt;
    logic        combine;
    logic        iq_il;
    logic        phase_hop;
    logic [23:0] start;
    logic        dispersed;
    logic [13:0] subslices;
    logic [23:0] spacing;
    logic        ext_il;
    logic [2:0]  cti_rows;
    logic [10:0] cti_start_row;
    logic        hti_inter;
    logic [3:0]  hti_ti_blocks;
    logic [11:0] hti_fec_max;
    logic [11:0] hti_fec;
    logic        hti_cell;
  } ldfb_plp_s;

  typedef struct packed {
    logic [7:0]  code;
    logic [4:0]  width;
    logic [23:0] value;
  } ldfb_fld_s;

  typedef struct packed {
    ldfb_state_e st;
    logic [4:0]  step;
    logic        rf_idx;
    logic [6:0]  plp_idx;
    ldfb_fld_s   fld;
    logic        valid;
    logic        done;
    logic        clamped;
  } ldfb_state_s;

  function automatic ldfb_fld_s mk_fld(input logic [2:0]  grp,
                                       input logic [4:0]  step,
                                       input logic [4:0]  wid,
                                       input logic [23:0] val);
    ldfb_fld_s f;
    f.code  = {grp, step};
    f.width = wid;
    f.value = val;
    return f;
  endfunction

endpackage

//--- verilog/ldfb_plp_fields.sv
// Purpose: value, width and presence of one pipe field
// Assumes: i_plp stable while its group is emitted
// Notes:   purely combinational
`timescale 1ns/1ps
`include "ldfb_defs.svh"

module ldfb_plp_fields
  import ldfb_pkg::*;
(
  // selection
  input  wire ldfb_plp_s  i_plp,
  input  wire logic [4:0] i_step,
  // result
  output ldfb_fld_s       o_fld,
  output logic            o_emit,
  output logic            o_id_clamped
);

  logic       clamp;
  logic [5:0] id_val;
  logic       is_cti;
  logic       bonded;

  always_comb begin
    clamp  = i_plp.id > `LDFB_PLP_ID_MAX;
    id_val = clamp ? 6'(`LDFB_PLP_ID_MAX) : i_plp.id[5:0];
    is_cti = i_plp.ti_mode == `LDFB_TI_MODE_CTI;
    bonded = i_plp.bond_total != 2'h0;
    o_emit = 1'b1;
    o_fld  = mk_fld(`LDFB_GRP_PLP, i_step, 5'h00, 24'h000000);
    case (i_step)
      `LDFB_P_ID:    o_fld.value = 24'(id_val);
      `LDFB_P_SLT:   o_fld.value = 24'(i_plp.slt);
      `LDFB_P_SIZE:  o_fld.value = i_plp.size;
      `LDFB_P_SCR:   o_fld.value = 24'(i_plp.scrambler);
      `LDFB_P_FEC:   o_fld.value = 24'(i_plp.fec);
      `LDFB_P_MOD:   o_fld.value = 24'(i_plp.modulation);
      `LDFB_P_COD:   o_fld.value = 24'(i_plp.code_rate);
      `LDFB_P_TI:    o_fld.value = 24'(i_plp.ti_mode);
      `LDFB_P_NBND:  o_fld.value = 24'(i_plp.bond_total);
      `LDFB_P_BID: begin
        o_fld.value = 24'(i_plp.bond_ident);
        o_emit      = bonded;
      end
      `LDFB_P_BFMT: begin
        o_fld.value = 24'(i_plp.bond_fmt);
        o_emit      = bonded;
      end
      `LDFB_P_SC:    o_fld.value = 24'(i_plp.combine);
      `LDFB_P_IQ:    o_fld.value = 24'(i_plp.iq_il);
      `LDFB_P_PH:    o_fld.value = 24'(i_plp.phase_hop);
      `LDFB_P_START: o_fld.value = i_plp.start;
      `LDFB_P_TYPE:  o_fld.value = 24'(i_plp.dispersed);
      `LDFB_P_NSS: begin
        o_fld.value = 24'(14'(i_plp.subslices - 14'h0001));
        o_emit      = i_plp.dispersed;
      end
      `LDFB_P_SSI: begin
        o_fld.value = i_plp.spacing;
        o_emit      = i_plp.dispersed;
      end
      `LDFB_P_EXT:   o_fld.value = 24'(i_plp.ext_il);
      `LDFB_P_DEPTH: o_fld.value = 24'(i_plp.cti_rows);
      `LDFB_P_ROW: begin
        o_fld.value = 24'(i_plp.cti_start_row);
        o_emit      = is_cti;
      end
      `LDFB_P_HINT: begin
        o_fld.value = 24'(i_plp.hti_inter);
        o_emit      = !is_cti;
      end
      `LDFB_P_HTIB: begin
        o_fld.value = 24'(i_plp.hti_ti_blocks);
        o_emit      = !is_cti;
      end
      `LDFB_P_HFMX: begin
        o_fld.value = 24'(12'(i_plp.hti_fec_max - 12'h001));
        o_emit      = !is_cti;
      end
      `LDFB_P_HFEC: begin
        o_fld.value = 24'(12'(i_plp.hti_fec - 12'h001));
        o_emit      = !is_cti;
      end
      `LDFB_P_HCI: begin
        o_fld.value = 24'(i_plp.hti_cell);
        o_emit      = !is_cti;
      end
      default:       o_emit = 1'b0;
    endcase
    o_fld.width  = field_width(i_step);
    o_id_clamped = clamp && (i_step == `LDFB_P_ID);
  end

  function automatic logic [4:0] field_width(input logic [4:0] s);
    case (s)
      `LDFB_P_ID:    field_width = 5'h06;
      `LDFB_P_SIZE:  field_width = 5'($bits(i_plp.size));
      `LDFB_P_SCR:   field_width = 5'($bits(i_plp.scrambler));
      `LDFB_P_FEC:   field_width = 5'($bits(i_plp.fec));
      `LDFB_P_MOD:   field_width = 5'($bits(i_plp.modulation));
      `LDFB_P_COD:   field_width = 5'($bits(i_plp.code_rate));
      `LDFB_P_TI:    field_width = 5'($bits(i_plp.ti_mode));
      `LDFB_P_NBND:  field_width = 5'($bits(i_plp.bond_total));
      `LDFB_P_BID:   field_width = 5'($bits(i_plp.bond_ident));
      `LDFB_P_BFMT:  field_width = 5'($bits(i_plp.bond_fmt));
      `LDFB_P_START: field_width = 5'($bits(i_plp.start));
      `LDFB_P_NSS:   field_width = 5'($bits(i_plp.subslices));
      `LDFB_P_SSI:   field_width = 5'($bits(i_plp.spacing));
      `LDFB_P_DEPTH: field_width = 5'($bits(i_plp.cti_rows));
      `LDFB_P_ROW:   field_width = 5'($bits(i_plp.cti_start_row));
      `LDFB_P_HTIB:  field_width = 5'($bits(i_plp.hti_ti_blocks));
      `LDFB_P_HFMX:  field_width = 5'($bits(i_plp.hti_fec_max));
      `LDFB_P_HFEC:  field_width = 5'($bits(i_plp.hti_fec));
      default:       field_width = 5'h01;
    endcase
  endfunction

endmodule

//--- verilog/ldfb_field_builder.sv
// Purpose: serialises frame, subframe and pipe detail fields to the framer
// Assumes: i_FRAME and i_SUB stay stable while o_BUSY is high, i_PLP while its pipe group is emitted
// Notes:   one field per accepted handshake; skipped fields cost one idle cycle
`timescale 1ns/1ps
`include "ldfb_defs.svh"

module ldfb_field_builder
  import ldfb_pkg::*;
(
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST_B,
  // start of a subframe
  input  wire logic        I_START,
  input  wire logic        I_WITH_HEADER,
  input  wire ldfb_frame_s I_FRAME,
  input  wire ldfb_sub_s   I_SUB,
  // pipe table lookup
  output logic [6:0]       O_PLP_IDX,
  input  wire ldfb_plp_s   I_PLP,
  // field stream to the framer
  output ldfb_fld_s        O_FLD,
  output logic             O_FLD_VALID,
  input  wire logic        I_FLD_READY,
  // status
  output logic             O_BUSY,
  output logic             O_DONE,
  output logic             O_ID_CLAMPED
);

  //////////////////////////////////////////////////////////////////////////////
  // field decoding

  function automatic ldfb_fld_s frame_fld(input logic [4:0] s, input ldfb_frame_s f);
    logic [2:0] others;
    others = (f.rf_total == 3'h0) ? 3'h0 : 3'(f.rf_total - 3'h1);
    case (s)
      `LDFB_F_VER: frame_fld = mk_fld(`LDFB_GRP_FRAME, s, 5'h03, 24'(f.version));
      `LDFB_F_NRF: frame_fld = mk_fld(`LDFB_GRP_FRAME, s, 5'h03, 24'(others));
      default:     frame_fld = mk_fld(`LDFB_GRP_FRAME, s, 5'h00, 24'h000000);
    endcase
  endfunction

  function automatic ldfb_fld_s rf_fld(input logic [4:0]  s,
                                       input logic        idx,
                                       input ldfb_frame_s f);
    logic [19:0] steps;
    // constant divider: scheduler supplies kHz, framer wants 10 kHz steps
    steps = f.rf_freq_khz[idx] / `LDFB_FREQ_STEP_KHZ;
    case (s)
      `LDFB_R_IDENT: rf_fld = mk_fld(`LDFB_GRP_RF, s, 5'h03, 24'(f.rf_ident[idx]));
      `LDFB_R_FREQ:  rf_fld = mk_fld(`LDFB_GRP_RF, s, 5'h14, 24'(steps));
      default:       rf_fld = mk_fld(`LDFB_GRP_RF, s, 5'h00, 24'h000000);
    endcase
  endfunction

  function automatic ldfb_fld_s sub_fld(input logic [4:0] s, input ldfb_sub_s b);
    logic [23:0] v;
    logic [4:0]  w;
    v = 24'h000000;
    w = 5'h01;
    case (s)
      `LDFB_S_MIMO: v = 24'(b.mimo);
      `LDFB_S_MISO: v = 24'(b.miso);
      `LDFB_S_FFT: begin
        v = 24'(b.fft);
        w = 5'h02;
      end
      `LDFB_S_RED: begin
        v = 24'(b.carrier_red);
        w = 5'h03;
      end
      `LDFB_S_GI: begin
        v = 24'(b.guard);
        w = 5'h04;
      end
      `LDFB_S_NSYM: begin
        v = 24'(12'(b.sym_total - 12'h001));
        w = 5'h0C;
      end
      `LDFB_S_SPP: begin
        v = 24'(b.pilot);
        w = 5'h05;
      end
      `LDFB_S_SPB: begin
        v = 24'(b.pilot_amp);
        w = 5'h03;
      end
      `LDFB_S_SBSF: v = 24'(b.sbs_first);
      `LDFB_S_SBSL: v = 24'(b.sbs_last);
      `LDFB_S_MUX:  v = 24'(b.concat);
      `LDFB_S_FI:   v = 24'(b.fi_en);
      `LDFB_S_NPLP: begin
        v = 24'(7'(b.plp_total - 7'h01));
        w = 5'h07;
      end
      default:      w = 5'h00;
    endcase
    sub_fld = mk_fld(`LDFB_GRP_SUB, s, w, v);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pipe field source

  ldfb_state_s q;
  ldfb_state_s next_q;
  ldfb_fld_s   plp_fld;
  logic        plp_emit;
  logic        plp_clamp;

  ldfb_plp_fields u_plp_fields (
    .i_plp        (I_PLP),
    .i_step       (q.step),
    .o_fld        (plp_fld),
    .o_emit       (plp_emit),
    .o_id_clamped (plp_clamp)
  );

  //////////////////////////////////////////////////////////////////////////////
  // sequencer

  logic       adv;
  logic [2:0] rf_others;

  always_comb begin
    next_q         = q;
    next_q.done    = 1'b0;
    next_q.clamped = 1'b0;
    rf_others      = (I_FRAME.rf_total == 3'h0) ? 3'h0 : 3'(I_FRAME.rf_total - 3'h1);
    // output slot is free when empty or being taken this cycle
    adv            = !q.valid || I_FLD_READY;
    if (q.valid && I_FLD_READY) begin
      next_q.valid = 1'b0;
    end
    case (q.st)
      ST_IDLE: begin
        if (I_START) begin
          next_q.st      = I_WITH_HEADER ? ST_FRAME : ST_SUB;
          next_q.step    = `LDFB_RST_STEP;
          next_q.rf_idx  = 1'b0;
          next_q.plp_idx = `LDFB_RST_IDX;
        end
      end
      ST_FRAME: begin
        if (adv) begin
          next_q.fld   = frame_fld(q.step, I_FRAME);
          next_q.valid = 1'b1;
          next_q.step  = 5'(q.step + 5'h01);
          if (q.step == `LDFB_F_LAST) begin
            next_q.step = `LDFB_RST_STEP;
            next_q.st   = (rf_others != 3'h0) ? ST_RF : ST_SUB;
          end
        end
      end
      ST_RF: begin
        if (adv) begin
          next_q.fld   = rf_fld(q.step, q.rf_idx, I_FRAME);
          next_q.valid = 1'b1;
          next_q.step  = `LDFB_R_FREQ;
          if (q.step == `LDFB_R_FREQ) begin
            next_q.step = `LDFB_RST_STEP;
            // only two partner slots exist, further partners are dropped
            if (q.rf_idx || (rf_others == 3'h1)) begin
              next_q.st = ST_SUB;
            end else begin
              next_q.rf_idx = 1'b1;
            end
          end
        end
      end
      ST_SUB: begin
        if (adv) begin
          next_q.fld   = sub_fld(q.step, I_SUB);
          next_q.valid = 1'b1;
          next_q.step  = 5'(q.step + 5'h01);
          if (q.step == `LDFB_S_LAST) begin
            next_q.step = `LDFB_RST_STEP;
            next_q.st   = ST_PLP;
          end
        end
      end
      ST_PLP: begin
        if (adv) begin
          if (plp_emit) begin
            next_q.fld     = plp_fld;
            next_q.valid   = 1'b1;
            next_q.clamped = plp_clamp;
          end
          next_q.step = 5'(q.step + 5'h01);
          if (q.step == `LDFB_P_LAST) begin
            next_q.step = `LDFB_RST_STEP;
            if (q.plp_idx == 7'(I_SUB.plp_total - 7'h01)) begin
              next_q.st   = ST_IDLE;
              next_q.done = 1'b1;
            end else begin
              next_q.plp_idx = 7'(q.plp_idx + 7'h01);
            end
          end
        end
      end
      default: begin
        next_q.st    = ST_IDLE;
        next_q.valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign O_PLP_IDX    = q.plp_idx;
  assign O_FLD        = q.fld;
  assign O_FLD_VALID  = q.valid;
  assign O_BUSY       = (q.st != ST_IDLE) || q.valid;
  assign O_DONE       = q.done;
  assign O_ID_CLAMPED = q.clamped;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  localparam logic [7:0] C_PID  = {`LDFB_GRP_PLP, `LDFB_P_ID};
  localparam logic [7:0] C_NSS  = {`LDFB_GRP_PLP, `LDFB_P_NSS};
  localparam logic [7:0] C_SSI  = {`LDFB_GRP_PLP, `LDFB_P_SSI};
  localparam logic [7:0] C_ROW  = {`LDFB_GRP_PLP, `LDFB_P_ROW};
  localparam logic [7:0] C_HINT = {`LDFB_GRP_PLP, `LDFB_P_HINT};
  localparam logic [7:0] C_NSYM = {`LDFB_GRP_SUB, `LDFB_S_NSYM};
  localparam logic [7:0] C_NPLP = {`LDFB_GRP_SUB, `LDFB_S_NPLP};
  localparam logic [7:0] C_NRF  = {`LDFB_GRP_FRAME, `LDFB_F_NRF};
  localparam logic [7:0] C_FREQ = {`LDFB_GRP_RF, `LDFB_R_FREQ};

  id_range_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    O_FLD_VALID && O_FLD.code == C_PID |-> O_FLD.value <= 24'h00003F)
    else $error("pipe identifier above 63");

  subslice_gate_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    O_FLD_VALID && (O_FLD.code == C_NSS || O_FLD.code == C_SSI)
      |-> I_PLP.dispersed)
    else $error("subslice field for contiguous pipe");

  symbol_count_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    O_FLD_VALID && O_FLD.code == C_NSYM |-> O_FLD.value == 24'(12'(I_SUB.sym_total - 12'h001)))
    else $error("symbol count not total minus one");

  pipe_count_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    O_FLD_VALID && O_FLD.code == C_NPLP |-> O_FLD.value == 24'(7'(I_SUB.plp_total - 7'h01)))
    else $error("pipe count not total minus one");

  cti_row_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    O_FLD_VALID && O_FLD.code == C_ROW |-> I_PLP.ti_mode == `LDFB_TI_MODE_CTI)
    else $error("start row outside convolutional mode");

  hybrid_gate_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    O_FLD_VALID && O_FLD.code == C_HINT |-> I_PLP.ti_mode != `LDFB_TI_MODE_CTI)
    else $error("hybrid field in convolutional mode");

  rf_others_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    O_FLD_VALID && O_FLD.code == C_NRF && I_FRAME.rf_total != 3'h0
      |-> O_FLD.value == 24'(3'(I_FRAME.rf_total - 3'h1)))
    else $error("bonded count includes present channel");

  freq_steps_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    O_FLD_VALID && O_FLD.code == C_FREQ
      |-> O_FLD.value[19:0] == I_FRAME.rf_freq_khz[q.rf_idx && (q.st != ST_RF)] / 20'h0000A)
    else $error("frequency not in 10 kHz steps");

  field_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    O_FLD_VALID && !I_FLD_READY |=> O_FLD_VALID && $stable(O_FLD))
    else $error("field changed while stalled");

  pipe_order_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    O_DONE |-> $past(q.plp_idx) == 7'(I_SUB.plp_total - 7'h01))
    else $error("done before last pipe group");

  sub_then_pipe_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    q.st == ST_SUB && next_q.st == ST_PLP |=> q.step == `LDFB_RST_STEP && q.plp_idx == 7'h00)
    else $error("pipe group did not start at its first field");

  // field on show, for the value checks below
  logic       on_plp;
  logic       on_sub;
  logic [4:0] at_step;
  assign on_plp  = O_FLD_VALID && O_FLD.code[7:5] == `LDFB_GRP_PLP;
  assign on_sub  = O_FLD_VALID && O_FLD.code[7:5] == `LDFB_GRP_SUB;
  assign at_step = O_FLD.code[4:0];

  slice_count_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    on_plp && at_step == `LDFB_P_NSS
      |-> O_FLD.value == 24'(14'(I_PLP.subslices - 14'h0001)))
    else $error("subslice count not minus one");

  slice_spacing_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    on_plp && at_step == `LDFB_P_SSI
      |-> O_FLD.value == I_PLP.spacing)
    else $error("subslice spacing lost");

  pipe_start_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    on_plp && at_step == `LDFB_P_START
      |-> O_FLD.value == I_PLP.start)
    else $error("pipe start lost");

  pipe_size_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    on_plp && at_step == `LDFB_P_SIZE
      |-> O_FLD.value == I_PLP.size)
    else $error("pipe size lost");

  cti_depth_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    on_plp && at_step == `LDFB_P_DEPTH
      |-> O_FLD.value == 24'(I_PLP.cti_rows))
    else $error("interleaver rows lost");

  ti_mode_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    on_plp && at_step == `LDFB_P_TI
      |-> O_FLD.value == 24'(I_PLP.ti_mode))
    else $error("interleave mode lost");

  phase_hop_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    on_plp && at_step == `LDFB_P_PH
      |-> O_FLD.value == 24'(I_PLP.phase_hop))
    else $error("phase hop flag lost");

  last_boundary_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    on_sub && at_step == `LDFB_S_SBSL
      |-> O_FLD.value == 24'(I_SUB.sbs_last))
    else $error("last boundary flag lost");

  carrier_red_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_B)
    on_sub && at_step == `LDFB_S_RED
      |-> O_FLD.value == 24'(I_SUB.carrier_red))
    else $error("carrier reduction lost");

endmodule

//--- verification/ldfb_framer_model.sv
// Purpose: framer side that takes detail fields and keeps them in order
// Assumes: a field is taken at a rising edge with valid and ready high
// Notes:   stall mode is ready one cycle in four to hold the builder back
`timescale 1ns/1ps

module ldfb_framer_model
  import ldfb_pkg::*;
(
  // clock and reset
  input  wire logic      i_clk,
  input  wire logic      i_rst_b,
  // field stream
  input  wire ldfb_fld_s i_fld,
  input  wire logic      i_valid,
  output logic           o_ready,
  // behaviour
  input  wire logic      i_stall
);
  ldfb_fld_s  got[$];
  logic [1:0] cnt;

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= 2'h0;
    end else begin
      cnt <= cnt + 2'h1;
      if (i_valid && o_ready) begin
        got.push_back(i_fld);
      end
    end
  end

  assign o_ready = !i_stall || (cnt == 2'h3);
endmodule

//--- verification/testbench.sv
// Purpose: self-checking bench of the detail field builder
// Assumes: the pipe table answers O_PLP_IDX in the same cycle
// Notes:   expected streams are built from the configuration alone
`timescale 1ns/1ps

module testbench;
  import ldfb_pkg::*;
  logic        clk;
  logic        rst_b;
  logic        start;
  logic        hdr;
  logic        stall;
  logic [6:0]  idx;
  logic        valid;
  logic        ready;
  logic        busy;
  logic        done;
  logic        clamp;
  ldfb_frame_s frame;
  ldfb_sub_s   sub;
  ldfb_plp_s   tbl [2];
  ldfb_fld_s   fld;
  ldfb_fld_s   exp_q[$];
  int          error_cnt = 0;
  int          checks = 0;
  int          n_done = 0;
  int          n_clamp = 0;

  ldfb_field_builder dut_u (.I_CLK(clk), .I_RST_B(rst_b), .I_START(start),
    .I_WITH_HEADER(hdr), .I_FRAME(frame), .I_SUB(sub), .O_PLP_IDX(idx),
    .I_PLP(tbl[idx[0]]), .O_FLD(fld), .O_FLD_VALID(valid), .I_FLD_READY(ready),
    .O_BUSY(busy), .O_DONE(done), .O_ID_CLAMPED(clamp));
  ldfb_framer_model partner_u (.i_clk(clk), .i_rst_b(rst_b), .i_fld(fld),
    .i_valid(valid), .o_ready(ready), .i_stall(stall));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // pulses are registered, so each is seen at exactly one edge
  always @(negedge clk) begin
    if (done === 1'b1) n_done++;
    if (clamp === 1'b1) n_clamp++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [23:0] g, input logic [23:0] e, input string m);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic add(input logic [7:0] c, input logic [23:0] v, input logic [4:0] w = 5'h00);
    exp_q.push_back('{code: c, width: w, value: v});
  endtask

  task automatic add_frame();
    add(8'h00, frame.version, 5'h03);
    add(8'h01, frame.rf_total - 24'h1, 5'h03);
    for (int i = 0; i < frame.rf_total - 1 && i < 2; i++) begin
      add(8'h20, frame.rf_ident[i], 5'h03);
      add(8'h21, frame.rf_freq_khz[i] / 24'h00000A, 5'h14);
    end
  endtask

  task automatic add_sub();
    logic [23:0] v[13];
    v = '{sub.mimo, sub.miso, sub.fft, sub.carrier_red, sub.guard,
          sub.sym_total - 24'h1, sub.pilot, sub.pilot_amp,
          sub.sbs_first, sub.sbs_last, sub.concat, sub.fi_en,
          sub.plp_total - 24'h1};
    foreach (v[i]) add({3'h2, 5'(i)}, v[i], (i == 5) ? 5'h0C : 5'h00);
  endtask

  task automatic add_plp(input ldfb_plp_s p);
    logic [23:0] v[26];
    logic [25:0] on;
    v = '{(p.id > 8'h3F) ? 24'h3F : p.id, p.slt, p.size, p.scrambler,
          p.fec, p.modulation, p.code_rate, p.ti_mode,
          p.bond_total, p.bond_ident, p.bond_fmt,
          p.combine, p.iq_il, p.phase_hop, p.start, p.dispersed,
          p.subslices - 24'h1, p.spacing, p.ext_il, p.cti_rows,
          p.cti_start_row, p.hti_inter, p.hti_ti_blocks,
          p.hti_fec_max - 24'h1, p.hti_fec - 24'h1, p.hti_cell};
    on = '1;
    on[10:9] = {2{p.bond_total != 2'h0}};
    on[17:16] = {2{p.dispersed}};
    on[20] = (p.ti_mode == 2'h1);
    on[25:21] = {5{p.ti_mode != 2'h1}};
    for (int i = 0; i < 26; i++) if (on[i]) add({3'h3, 5'(i)}, v[i], (i == 0) ? 5'h06 : 5'h00);
  endtask

  task automatic run(input logic h, input logic poke);
    int n;
    exp_q.delete();
    partner_u.got.delete();
    n_done = 0;
    n_clamp = 0;
    start = 1'b1;
    hdr = h;
    @(negedge clk);
    start = 1'b0;
    repeat (4) @(negedge clk);
    start = poke;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t busy never dropped", $time);
    end
    repeat (4) @(negedge clk);
  endtask

  task automatic check_stream(input int nclamp);
    cmp(24'(partner_u.got.size()), 24'(exp_q.size()), "field count");
    foreach (exp_q[i]) begin
      if (i < partner_u.got.size()) begin
        cmp(partner_u.got[i].code, exp_q[i].code, "field code");
        cmp(partner_u.got[i].value, exp_q[i].value, "field value");
        if (exp_q[i].width != 5'h00) cmp(partner_u.got[i].width, exp_q[i].width, "width");
      end
    end
    cmp(24'(n_done), 24'h1, "done pulses");
    cmp(24'(n_clamp), 24'(nclamp), "clamp pulses");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // slow framer, header with two partners, two pipes of opposite shapes
  task automatic test_header_stall();
    stall = 1'b1;
    frame = '{version: 3'h2, rf_total: 3'h3, rf_ident: {3'h5, 3'h2},
              rf_freq_khz: {20'h8B2A9, 20'h12345}};
    sub = '{mimo: 1'b1, fft: 2'h2, carrier_red: 3'h4, guard: 4'h9, sym_total: 12'h100,
            pilot: 5'h13, pilot_amp: 3'h5, sbs_first: 1'b1, concat: 1'b1,
            plp_total: 7'h02, default: '0};
    tbl[0] = '{id: 8'h05, slt: 1'b1, size: 24'h00ABCD, ti_mode: 2'h1, modulation: 4'h3,
               start: 24'h000010, cti_rows: 3'h4, cti_start_row: 11'h2A5, default: '0};
    tbl[1] = '{id: 8'h46, size: 24'h001000, ti_mode: 2'h2, bond_total: 2'h1,
               bond_ident: 3'h6, bond_fmt: 2'h1, combine: 1'b1, phase_hop: 1'b1,
               dispersed: 1'b1, subslices: 14'h0004, spacing: 24'h000800, ext_il: 1'b1,
               hti_inter: 1'b1, hti_ti_blocks: 4'h3, hti_fec_max: 12'h010,
               hti_fec: 12'h00C, hti_cell: 1'b1, default: '0};
    run(1'b1, 1'b0);
    add_frame();
    add_sub();
    add_plp(tbl[0]);
    add_plp(tbl[1]);
    check_stream(1);
    $display("test header_stall done");
  endtask

  // prompt framer, one partner, one pipe, a second start while busy must be ignored
  task automatic test_refuse_prompt();
    stall = 1'b0;
    frame = '{version: 3'h1, rf_total: 3'h2, rf_ident: {3'h0, 3'h3},
              rf_freq_khz: {20'h00000, 20'h0000F}};
    sub = '{miso: 1'b1, sym_total: 12'h001, sbs_last: 1'b1, fi_en: 1'b1,
            plp_total: 7'h01, default: '0};
    tbl[0] = '{id: 8'h3F, ti_mode: 2'h0, bond_total: 2'h2, bond_ident: 3'h1,
               bond_fmt: 2'h2, iq_il: 1'b1, dispersed: 1'b1, subslices: 14'h0001,
               hti_fec_max: 12'h001, hti_fec: 12'h001, default: '0};
    run(1'b1, 1'b1);
    add_frame();
    add_sub();
    add_plp(tbl[0]);
    check_stream(0);
    $display("test refuse_prompt done");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    start = 1'b0;
    hdr = 1'b0;
    stall = 1'b0;
    frame = '0;
    sub = '0;
    tbl[0] = '0;
    tbl[1] = '0;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    test_header_stall();
    test_refuse_prompt();
    end_sim();
  end

  // both tests need well under a thousand cycles each
  initial begin
    #(25 * 20000);
    error_cnt++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    end_sim();
  end
endmodule
